// ==== logic/ndsf_cfg.svh ====
// Offsets, field positions, command codes and counts of the diagnostic flag block
`ifndef NDSF_CFG_SVH
`define NDSF_CFG_SVH

`define NDSF_OFF_DIAG     12'h000
`define NDSF_OFF_SUCC     12'h004
`define NDSF_OFF_CMD      12'h008
`define NDSF_OFF_IMASK    12'h00c
`define NDSF_OFF_NODE     12'h010
`define NDSF_OFF_TENT     12'h014
`define NDSF_OFF_CFG      12'h018
`define NDSF_OFF_CTRL     12'h01c
`define NDSF_OFF_ISTAT    12'h020

`define NDSF_BIT_SELFREC  7
`define NDSF_BIT_DUP      6
`define NDSF_BIT_RXACT    5
`define NDSF_BIT_TOKEN    4
`define NDSF_BIT_EXCESSIVE_REFUSAL_FLAG   3
`define NDSF_BIT_TENT     2
`define NDSF_BIT_SUCC     1
`define NDSF_BIT_RECONFIGURATION_FLAG    0

`define NDSF_CMD_DIS_TX   8'h01
`define NDSF_CMD_CLR_FLG  8'h1e
`define NDSF_CMD_EN_TX    3'h3

`define NDSF_NAK_LONG     8'h80
`define NDSF_NAK_SHORT    8'h04

`define NDSF_RST_FLAGS    8'h00
`define NDSF_RST_NODE     8'h00
`endif

// ==== logic/ndsf_diag.sv ====
// Diagnostic status flags of a token-passing node with an APB register slave
`timescale 1ns/1ps
`include "ndsf_cfg.svh"
module ndsf_diag
	import ndsf_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire ndsf_obs_t   obs,
	output logic             irq,
	output logic             tx_enabled,
	output logic             tx_pending,
	output logic             tx_available
);
	typedef struct packed {
		logic [7:0]  flags;
		logic [7:0]  istat;
		logic [7:0]  imask;
		logic [7:0]  node_id;
		logic [7:0]  tent_id;
		logic [7:0]  succ_id;
		logic        nak_short;
		logic        tx_en;
		logic        tx_pend;
		logic        tx_avail;
		logic        avail_wait;
		logic        reconfiguration_flag;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
	} ndsf_state_t;

	ndsf_state_t s_r;
	ndsf_state_t s_nxt;

	logic dup_set;
	logic tent_set;
	logic exc_set;
	logic acc;
	logic wr;
	logic rd;
	logic cmd_clr;
	logic cmd_dis;
	logic [7:0] fset;
	logic [7:0] fclr;
	logic [7:0] iset;

	function automatic logic [7:0] bitv(input int pos);
		bitv = 8'h01 << pos;
	endfunction : bitv

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction : hit

	ndsf_token_match u_match (
		.pclk     (pclk),
		.presetn  (presetn),
		.obs      (obs),
		.node_id  (s_r.node_id),
		.tent_id  (s_r.tent_id),
		.tx_en    (s_r.tx_en),
		.dup_set  (dup_set),
		.tent_set (tent_set)
	);

	ndsf_nak_count u_nak (
		.pclk      (pclk),
		.presetn   (presetn),
		.nak       (obs.nak),
		.sel_short (s_r.nak_short),
		.clr       (cmd_clr),
		.exc_set   (exc_set)
	);

	// Access completes at the edge where pready is high
	assign acc     = psel && penable && s_r.pready;
	assign wr      = acc && pwrite && pstrb[0];
	assign rd      = acc && !pwrite;
	assign cmd_clr = wr && hit(paddr, `NDSF_OFF_CMD) && (pwdata[7:0] == `NDSF_CMD_CLR_FLG);
	assign cmd_dis = wr && hit(paddr, `NDSF_OFF_CMD) && (pwdata[7:0] == `NDSF_CMD_DIS_TX);

	always_comb
	begin
		fset = 8'h00;
		fclr = 8'h00;
		iset = 8'h00;
		if (obs.lost_token_exp)
			fset = fset | bitv(`NDSF_BIT_SELFREC);
		if (dup_set)
			fset = fset | bitv(`NDSF_BIT_DUP);
		if (obs.rx_in)
			fset = fset | bitv(`NDSF_BIT_RXACT);
		if (obs.token_obs && !obs.own_token)
			fset = fset | bitv(`NDSF_BIT_TOKEN);
		if (exc_set)
			fset = fset | bitv(`NDSF_BIT_EXCESSIVE_REFUSAL_FLAG);
		if (tent_set)
			fset = fset | bitv(`NDSF_BIT_TENT);
		if (obs.succ_upd)
			fset = fset | bitv(`NDSF_BIT_SUCC);
		if (rd && hit(paddr, `NDSF_OFF_DIAG))
			fclr = fclr | bitv(`NDSF_BIT_DUP);
		if (cmd_clr)
			fclr = fclr | bitv(`NDSF_BIT_EXCESSIVE_REFUSAL_FLAG);
		if (rd && hit(paddr, `NDSF_OFF_SUCC))
			fclr = fclr | bitv(`NDSF_BIT_SUCC);
		if (exc_set)
			iset = iset | bitv(`NDSF_BIT_EXCESSIVE_REFUSAL_FLAG);
		if (obs.succ_upd)
			iset = iset | bitv(`NDSF_BIT_SUCC);
		if (obs.line_idle_exp)
			iset = iset | bitv(`NDSF_BIT_RECONFIGURATION_FLAG);
	end

	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.pready  = psel && penable && !s_r.pready;
		s_nxt.pslverr = 1'b0;
		// Set terms are ORed in after the clears
		s_nxt.flags = (s_r.flags & ~fclr) | fset;
		if (obs.succ_upd)
			s_nxt.succ_id = obs.succ_id;
		if (obs.line_idle_exp)
			s_nxt.reconfiguration_flag = 1'b1;
		else if (cmd_clr)
			s_nxt.reconfiguration_flag = 1'b0;
		if (obs.token_to_us && s_r.avail_wait)
		begin
			s_nxt.tx_avail   = 1'b1;
			s_nxt.avail_wait = 1'b0;
		end
		if (wr)
		begin
			case (paddr)
				`NDSF_OFF_CMD:
				begin
					if (cmd_dis)
					begin
						s_nxt.tx_pend    = 1'b0;
						s_nxt.tx_en      = 1'b0;
						s_nxt.avail_wait = 1'b1;
					end
					else if (pwdata[2:0] == `NDSF_CMD_EN_TX)
					begin
						s_nxt.tx_en      = 1'b1;
						s_nxt.tx_pend    = 1'b1;
						s_nxt.tx_avail   = 1'b0;
						s_nxt.avail_wait = 1'b0;
					end
				end
				`NDSF_OFF_IMASK: s_nxt.imask = pwdata[7:0];
				`NDSF_OFF_NODE:  s_nxt.node_id = pwdata[7:0];
				`NDSF_OFF_TENT:  s_nxt.tent_id = pwdata[7:0];
				`NDSF_OFF_CFG:   s_nxt.nak_short = pwdata[0];
				`NDSF_OFF_ISTAT: ;
				`NDSF_OFF_DIAG,
				`NDSF_OFF_SUCC,
				`NDSF_OFF_CTRL:  ;
				default:         ;
			endcase
		end
		// Write one clears, but an event in the same cycle stays
		s_nxt.istat = (s_r.istat & ~((wr && hit(paddr, `NDSF_OFF_ISTAT)) ? pwdata[7:0] : 8'h00)) | iset;
		s_nxt.irq   = |(s_nxt.istat & s_nxt.imask);
		if (psel && penable && !s_r.pready)
		begin
			s_nxt.prdata = 32'h0000_0000;
			case (paddr)
				// Reserved bit 0 reads as zero; software must not rely on it
				`NDSF_OFF_DIAG:  s_nxt.prdata[7:0] = s_r.flags & 8'hfe;
				`NDSF_OFF_SUCC:  s_nxt.prdata[7:0] = s_r.succ_id;
				`NDSF_OFF_CMD:   ;
				`NDSF_OFF_IMASK: s_nxt.prdata[7:0] = s_r.imask;
				`NDSF_OFF_NODE:  s_nxt.prdata[7:0] = s_r.node_id;
				`NDSF_OFF_TENT:  s_nxt.prdata[7:0] = s_r.tent_id;
				`NDSF_OFF_CFG:   s_nxt.prdata[0] = s_r.nak_short;
				`NDSF_OFF_CTRL:  s_nxt.prdata[3:0] = {s_r.reconfiguration_flag, s_r.tx_avail, s_r.tx_pend, s_r.tx_en};
				`NDSF_OFF_ISTAT: s_nxt.prdata[7:0] = s_r.istat;
				default:         s_nxt.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r          <= '0;
			s_r.flags    <= `NDSF_RST_FLAGS;
			s_r.node_id  <= `NDSF_RST_NODE;
			s_r.tx_avail <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign prdata       = s_r.prdata;
	assign pready       = s_r.pready;
	assign pslverr      = s_r.pslverr;
	assign irq          = s_r.irq;
	assign tx_enabled   = s_r.tx_en;
	assign tx_pending   = s_r.tx_pend;
	assign tx_available = s_r.tx_avail;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_diag_read;
		rd && paddr == `NDSF_OFF_DIAG && !dup_set;
	endsequence

	sequence s_dis_cmd;
		cmd_dis;
	endsequence

	a_selfrec_set: assert property (obs.lost_token_exp |=> s_r.flags[7])
		else $error("self reconfig flag not set");
	a_dup_rdclr: assert property (s_diag_read |=> !s_r.flags[6])
		else $error("duplicate flag survived status read");
	a_dup_online: assert property (s_r.tx_en && obs.token_to_us && !cmd_dis |=> ##1 s_r.flags[6])
		else $error("online token did not set duplicate flag");
	a_rxact_set: assert property (obs.rx_in |=> s_r.flags[5])
		else $error("receive activity not flagged");
	a_token_seen: assert property (obs.token_obs && !obs.own_token |=> s_r.flags[4])
		else $error("foreign token not flagged");
	a_excessive_refusal_flag_hold: assert property (s_r.flags[3] && !cmd_clr |=> s_r.flags[3])
		else $error("excess refusal flag cleared without command");
	a_succ_rdclr: assert property (rd && paddr == `NDSF_OFF_SUCC && !obs.succ_upd |=> !s_r.flags[1])
		else $error("successor flag survived successor read");
	a_succ_set: assert property (obs.succ_upd |=> s_r.flags[1] && s_r.istat[1])
		else $error("successor update not flagged");
	a_irq_level: assert property (s_r.istat[3] && s_r.imask[3] |-> s_r.irq)
		else $error("masked in excess event gave no interrupt");
	a_dis_offline: assert property (s_dis_cmd |=> !s_r.tx_en && !s_r.tx_pend)
		else $error("disable command left transmitter on");
	a_reconfiguration_flag_set: assert property (obs.line_idle_exp |=> s_r.reconfiguration_flag ##0 s_r.istat[0])
		else $error("line idle timeout not flagged");
	a_rsv_bit_low: assert property (s_r.pready && !pwrite && paddr == `NDSF_OFF_DIAG |-> !s_r.prdata[0])
		else $error("reserved status bit set");
endmodule : ndsf_diag

// ==== logic/ndsf_nak_count.sv ====
// Counts refusals to the free buffer enquiry and flags an excess
`timescale 1ns/1ps
`include "ndsf_cfg.svh"
module ndsf_nak_count
	import ndsf_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic nak,
	input  wire logic sel_short,
	input  wire logic clr,
	output logic      exc_set
);
	ndsf_nak_t  s_r;
	ndsf_nak_t  s_nxt;
	logic [7:0] limit;

	always_comb
	begin
		limit         = sel_short ? `NDSF_NAK_SHORT : `NDSF_NAK_LONG;
		s_nxt         = s_r;
		s_nxt.exc_set = 1'b0;
		if (clr)
			s_nxt.cnt = 8'h00;
		else if (nak && (s_r.cnt < limit))
		begin
			s_nxt.cnt     = s_r.cnt + 8'h01;
			s_nxt.exc_set = (s_r.cnt + 8'h01 == limit);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign exc_set = s_r.exc_set;
endmodule : ndsf_nak_count

// ==== logic/ndsf_pkg.sv ====
// Types shared by the diagnostic flag block
package ndsf_pkg;
	typedef struct packed {
		logic       rx_in;
		logic       token_obs;
		logic       own_token;
		logic [7:0] did0;
		logic [7:0] did1;
		logic       trail_ok;
		logic       response;
		logic       token_to_us;
		logic       lost_token_exp;
		logic       line_idle_exp;
		logic       nak;
		logic       succ_upd;
		logic [7:0] succ_id;
	} ndsf_obs_t;

	typedef struct packed {
		logic       pend;
		logic [7:0] did0;
		logic [7:0] did1;
		logic       trail_ok;
		logic       dup_set;
		logic       tent_set;
	} ndsf_match_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic       exc_set;
	} ndsf_nak_t;
endpackage : ndsf_pkg

// ==== logic/ndsf_token_match.sv ====
// Token identifier comparison for duplicate and tentative identity detection
`timescale 1ns/1ps
`include "ndsf_cfg.svh"
module ndsf_token_match
	import ndsf_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire ndsf_obs_t  obs,
	input  wire logic [7:0] node_id,
	input  wire logic [7:0] tent_id,
	input  wire logic       tx_en,
	output logic            dup_set,
	output logic            tent_set
);
	ndsf_match_t s_r;
	ndsf_match_t s_nxt;

	always_comb
	begin
		s_nxt          = s_r;
		s_nxt.dup_set  = 1'b0;
		s_nxt.tent_set = 1'b0;
		if (s_r.pend && obs.response)
		begin
			s_nxt.pend     = 1'b0;
			s_nxt.dup_set  = (s_r.did0 == node_id) && (s_r.did1 == node_id) && s_r.trail_ok;
			s_nxt.tent_set = (s_r.did0 == tent_id);
		end
		if (obs.token_obs)
		begin
			s_nxt.pend     = 1'b1;
			s_nxt.did0     = obs.did0;
			s_nxt.did1     = obs.did1;
			s_nxt.trail_ok = obs.trail_ok;
		end
		// Online the node answers its own token, so it always matches
		if (tx_en && obs.token_to_us)
			s_nxt.dup_set = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign dup_set  = s_r.dup_set;
	assign tent_set = s_r.tent_set;
endmodule : ndsf_token_match

// ==== test/ndsf_diag_tb_top.sv ====
// Self-checking bench of the diagnostic flag block
`timescale 1ns/1ps
`include "ndsf_cfg.svh"
module ndsf_diag_tb_top;
	import ndsf_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        tx_enabled;
	logic        tx_pending;
	logic        tx_available;
	ndsf_obs_t   obs;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          seed = 51;
	int          k;
	logic [31:0] rv;
	logic        er;
	logic        t;
	logic [7:0]  nid;
	logic [7:0]  tid;
	logic [7:0]  a;
	logic [7:0]  b;
	logic [7:0]  hold;

	always #2 pclk = ~pclk;

	ndsf_net_model u_net (.pclk(pclk), .obs(obs));

	ndsf_diag u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.obs(obs), .irq(irq), .tx_enabled(tx_enabled), .tx_pending(tx_pending), .tx_available(tx_available));

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Outputs are read right after the edge, before it updates them, so the edge's own sample is seen
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int   i;
		logic hit;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			hit = pready;
			rv = prdata;
			er = pslverr;
			i++;
		end
		while (hit !== 1'b1 && i < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (hit !== 1'b1)
		begin
			fail_count++;
			stop_test();
		end
	endtask : apb

	// Duplicate and tentative hits that one token and its response should raise
	function automatic logic [7:0] hits(input logic [7:0] x, input logic [7:0] y, input logic tr);
		return ((x == nid && y == nid && tr) ? 8'h40 : 8'h00) | ((x == tid) ? 8'h04 : 8'h00);
	endfunction : hits

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("diag reset", rv & 32'hfe, 32'h0);
		chk("tx available reset", tx_available, 1'b1);
		u_net.ev(1, 8'h00);
		u_net.ev(2, 8'h00);
		u_net.tok(8'h5a, 8'h5a, 1'b1, 1'b1);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("rx and self reconfig", rv & 32'hb0, 32'ha0);
		u_net.tok(8'h5a, 8'h33, 1'b1, 1'b0);
		u_net.ev(6, 8'h00);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("token seen", rv & 32'h10, 32'h10);
		apb(1'b0, `NDSF_OFF_CTRL, 32'h0);
		chk("reconfig", rv & 32'h08, 32'h08);
		nid = 8'($random(seed)) | 8'h01;
		tid = nid ^ 8'h80;
		apb(1'b1, `NDSF_OFF_NODE, {24'h0, nid});
		apb(1'b1, `NDSF_OFF_TENT, {24'h0, tid});
		hold = 8'h00;
		for (k = 0; k < 9; k++)
		begin
			a = (k % 3 == 0) ? nid : ((k % 3 == 1) ? tid : 8'($random(seed)));
			b = (k < 4) ? a : 8'($random(seed));
			t = (k == 0) | 1'($random(seed));
			u_net.tok(a, b, t, 1'b0);
			u_net.ev(0, 8'h00);
			hold = (hold & 8'h04) | hits(a, b, t);
			apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
			chk("dup and tentative", rv & 32'h44, {24'h0, hold});
		end
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("dup read clear", rv & 32'h40, 32'h0);
		apb(1'b1, `NDSF_OFF_IMASK, 32'h02);
		a = 8'($random(seed));
		u_net.ev(4, a);
		chk("irq successor", irq, 1'b1);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("successor set", rv & 32'h02, 32'h02);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("successor kept", rv & 32'h02, 32'h02);
		apb(1'b0, `NDSF_OFF_SUCC, 32'h0);
		chk("successor id", rv, {24'h0, a});
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("successor cleared", rv & 32'h02, 32'h0);
		apb(1'b1, `NDSF_OFF_ISTAT, 32'h02);
		repeat (2) @(negedge pclk);
		chk("irq cleared", irq, 1'b0);
		apb(1'b1, `NDSF_OFF_CFG, 32'h01);
		repeat (3) u_net.ev(3, 8'h00);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("refusals below limit", rv & 32'h08, 32'h0);
		u_net.ev(3, 8'h00);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("refusals at limit", rv & 32'h08, 32'h08);
		chk("irq masked out", irq, 1'b0);
		apb(1'b1, `NDSF_OFF_IMASK, 32'h08);
		repeat (2) @(negedge pclk);
		chk("irq refusals", irq, 1'b1);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("refusal flag kept", rv & 32'h08, 32'h08);
		apb(1'b1, `NDSF_OFF_CMD, {24'h0, `NDSF_CMD_CLR_FLG});
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("refusal flag cleared", rv & 32'h08, 32'h0);
		apb(1'b1, `NDSF_OFF_CFG, 32'h00);
		repeat (`NDSF_NAK_LONG - 8'h01) u_net.ev(3, 8'h00);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("long limit below", rv & 32'h08, 32'h0);
		u_net.ev(3, 8'h00);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("long limit reached", rv & 32'h08, 32'h08);
		apb(1'b0, 12'h0ff, 32'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
		apb(1'b1, `NDSF_OFF_CMD, 32'h03);
		repeat (2) @(negedge pclk);
		chk("tx on", {tx_enabled, tx_pending}, 32'h3);
		u_net.ev(5, 8'h00);
		apb(1'b0, `NDSF_OFF_DIAG, 32'h0);
		chk("dup while online", rv & 32'h40, 32'h40);
		apb(1'b1, `NDSF_OFF_CMD, {24'h0, `NDSF_CMD_DIS_TX});
		repeat (2) @(negedge pclk);
		chk("tx off", {tx_enabled, tx_pending}, 32'h0);
		chk("tx waits for token", tx_available, 1'b0);
		u_net.ev(5, 8'h00);
		chk("tx available", tx_available, 1'b1);
		stop_test();
	end
endmodule : ndsf_diag_tb_top

// ==== test/ndsf_net_model.sv ====
// Network side model: other nodes sending tokens, responses and events
`timescale 1ns/1ps
module ndsf_net_model
	import ndsf_pkg::*;
(
	input  wire logic pclk,
	output ndsf_obs_t obs
);
	initial obs = '0;

	// Released id bytes show the inverse so a stale value never matches by luck
	task automatic tok(input logic [7:0] a, input logic [7:0] b, input logic t, input logic o);
		@(posedge pclk);
		obs.token_obs <= 1'b1;
		obs.did0 <= a;
		obs.did1 <= b;
		obs.trail_ok <= t;
		obs.own_token <= o;
		@(posedge pclk);
		obs.token_obs <= 1'b0;
		obs.did0 <= ~a;
		obs.did1 <= ~b;
		obs.trail_ok <= ~t;
	endtask : tok

	// Kinds: 0 response, 1 rx data, 2 lost token, 3 refusal, 4 successor, 5 token to us, 6 line idle
	task automatic ev(input int k, input logic [7:0] s);
		@(posedge pclk);
		obs.succ_id <= s;
		{obs.line_idle_exp, obs.token_to_us, obs.succ_upd, obs.nak, obs.lost_token_exp, obs.rx_in,
			obs.response} <= 7'h01 << k;
		@(posedge pclk);
		{obs.line_idle_exp, obs.token_to_us, obs.succ_upd, obs.nak, obs.lost_token_exp, obs.rx_in,
			obs.response} <= 7'h00;
		obs.succ_id <= ~s;
		repeat (3) @(posedge pclk);
	endtask : ev
endmodule : ndsf_net_model
